// ---- jsm_ctrl.sv ----
// jack sense mute, down-mix, spread and eq bypass control
//
// Operation
// RULE1: three-bit mute selector picks jack mute pattern; zero mutes nothing.
// RULE2: code 001: detect b low mutes line, center/bass, rear; high mutes mono.
// RULE3: code 010: detect b low mutes hp, center/bass, rear; high mutes mono.
// RULE4: code 100: hp active; pattern set by both detects.
// RULE5: code 101: detect b low mutes all but mono; high mutes mono.
// RULE6: forced mute silences an output regardless of its volume control.
// RULE7: unmuted output follows only its own volume control.
// RULE8: detect 0 means empty jack, 1 means plug inserted.
// RULE9: gate a set and detect a high activates down-mix.
// RULE10: gate b set and detect b high activates down-mix.
// RULE11: down-mix folds six channels to stereo for line or headphone.
// RULE12: spread gate set and a detect high enables two-to-six spread.
// RULE13: mixdown select 10 sums center/bass, 11 adds rear, 0x none.
// RULE14: per-detect mode bit; interrupt mode raises irq on state change.
// RULE15: per-detect eq bypass enable; detect high then bypasses equalizer.
// RULE16: reserved mute codes apply no jack-driven muting.
//
// register map seen by software
//   jack_sense_control, bit by bit:
//   15    spread gate, a plug present may spread two channels to six
//   14    detect b down-mix gate
//   13    detect a down-mix gate
//   12:10 mute selector
//   9     detect b equalizer bypass enable
//   8     detect a equalizer bypass enable
//   7:6   unused, read as zero
//   5     detect b interrupt mode
//   4     detect a interrupt mode
//   3     detect b synchronised state, read only
//   2     detect a synchronised state, read only
//   1     detect b change flag, write 0 clears
//   0     detect a change flag, write 0 clears
//   mixdown select sits alone in bits 1:0 of the second register
//
// timing: detect pins pass two flops, so jack outputs trail a pin
// change by three edges and a register write by two
//
// limitations and choices
//   reserved mute codes fall back to no muting, so a bad write cannot
//   silence every speaker at once
//   a jack gated down-mix with the select field clear is reported as
//   the six to two type, since the jack path has no type of its own
//   the spread output also follows the software switch port directly
//   change flags set on any synchronised edge whatever the mode bit;
//   the mode bit only decides whether the flag reaches the irq output
//   a flag clear written in the same cycle as a new edge loses to the
//   edge, so no plug event is ever dropped
//   a pin that glitches for less than two clocks may still raise a
//   flag; there is no debounce here, that is left to the jack network
//   read data is zero whenever the read strobe was low
//   writes to an unmapped address are ignored and read back as zero
//   the status bits read the synchronised level, not the raw pin
//   every output is a flop, so nothing glitches towards the amplifiers
//   mute outputs are high while forced; volume logic then holds off
`timescale 1ns/1ps
`default_nettype none
module jsm_ctrl (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_plug_detect_a,
  input wire logic i_plug_detect_b,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_spread_sw,
  output logic [15:0] o_rdata,
  output logic o_mute_headphone,
  output logic o_mute_line,
  output logic o_mute_center_bass,
  output logic o_mute_rear,
  output logic o_mute_mono,
  output logic o_mixdown_active,
  output logic [1:0] o_mixdown_type,
  output logic o_spread_active,
  output logic o_eq_bypass,
  output logic o_irq
);

  // all state of the block, registered as one word
  typedef struct packed {
    // detect synchronisers and last synchronised value
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic det_a_q;
    logic det_b_q;
    // software visible registers and change flags
    logic [15:0] ctrl;
    logic [1:0] mix_sel;
    logic flag_a;
    logic flag_b;
    // registered outputs
    logic [15:0] rdata;
    logic [4:0] mute;
    logic mix_act;
    logic [1:0] mix_type;
    logic spread;
    logic eqb;
    logic irq;
  } jsm_state_t;

  jsm_state_t st_r;
  jsm_state_t st_nxt;

  // mute pattern from selector and detects, order hp line cb rear mono
  function automatic logic [4:0] jsm_mute_f(input logic [2:0] sel,
                                             input logic a,
                                             input logic b);
    logic [4:0] m;
    m = jsm_pkg::MV_NONE;
    unique case (sel)
      jsm_pkg::MS_NONE: begin // RULE1
        // detects ignored, every output follows its volume control
        m = jsm_pkg::MV_NONE;
      end
      jsm_pkg::MS_LINE_B: begin // RULE2
        if (b) begin
          m = jsm_pkg::MV_MONO; // plug in b: six channel speakers
        end else begin
          m = jsm_pkg::MV_LINE_CB_REAR;
        end
      end
      jsm_pkg::MS_HP_B: begin // RULE3
        if (b) begin
          m = jsm_pkg::MV_MONO; // plug in b: six channel speakers
        end else begin
          m = jsm_pkg::MV_HP_CB_REAR;
        end
      end
      jsm_pkg::MS_MIXED: begin // RULE4
        // headphone never muted; detect a only matters with b empty
        if (b) begin
          m = jsm_pkg::MV_ALL_BUT_HP;
        end else if (a) begin
          m = jsm_pkg::MV_MONO;
        end else begin
          m = jsm_pkg::MV_LINE_CB_REAR;
        end
      end
      jsm_pkg::MS_ALL_B: begin // RULE5
        if (b) begin
          m = jsm_pkg::MV_MONO; // plug in b: six channel speakers
        end else begin
          m = jsm_pkg::MV_HP_LINE_CB_REAR;
        end
      end
      default: begin // RULE16
        // reserved codes: no jack muting rather than a guess
        m = jsm_pkg::MV_NONE;
      end
    endcase
    return m;
  endfunction : jsm_mute_f

  // register decode, shared by the write and read paths
  function automatic logic jsm_hit_f(input logic [7:0] addr,
                                     input logic [7:0] reg_addr);
    logic hit;
    hit = (addr == reg_addr);
    return hit;
  endfunction : jsm_hit_f

  // a jack gate: enable bit and synchronised detect both high
  function automatic logic jsm_gate_f(input logic en_a,
                                      input logic a,
                                      input logic en_b,
                                      input logic b);
    logic on;
    on = (en_a && a) || (en_b && b);
    return on;
  endfunction : jsm_gate_f

  // edge of a synchronised detect against its previous value
  function automatic logic jsm_change_f(input logic now_v,
                                        input logic last_v);
    logic chg;
    chg = now_v ^ last_v;
    return chg;
  endfunction : jsm_change_f

  // change flag: a change sets it, a written zero clears it, set wins
  function automatic logic jsm_flag_f(input logic flag,
                                      input logic chg,
                                      input logic clr);
    logic f;
    f = flag;
    if (clr) begin
      f = 1'b0;
    end
    if (chg) begin
      f = 1'b1; // an event in the clear cycle is not lost
    end
    return f;
  endfunction : jsm_flag_f

  // interrupt request from one detect: flag kept and interrupt mode on
  function automatic logic jsm_irq_f(input logic flag,
                                     input logic mode);
    logic req;
    req = flag && mode;
    return req;
  endfunction : jsm_irq_f

  // spread request: software switch, or gate set and a plug present
  function automatic logic jsm_spread_f(input logic sw,
                                        input logic gate,
                                        input logic a,
                                        input logic b);
    logic on;
    on = sw || (gate && (a || b));
    return on;
  endfunction : jsm_spread_f

  // down-mix type, software select first, jack gate gives six to two
  function automatic logic [1:0] jsm_mix_type_f(input logic [1:0] sel,
                                                input logic jack_on);
    logic [1:0] t;
    t = jsm_pkg::MT_OFF;
    if (sel == jsm_pkg::MX_CB_REAR) begin
      t = jsm_pkg::MT_CB_REAR;
    end else if (sel == jsm_pkg::MX_CB) begin
      t = jsm_pkg::MT_CB;
    end else if (jack_on) begin
      t = jsm_pkg::MT_CB_REAR;
    end else begin
      t = jsm_pkg::MT_OFF;
    end
    return t;
  endfunction : jsm_mix_type_f

  // read word of jack_sense_control with live status and flags
  function automatic logic [15:0] jsm_ctrl_word_f(input logic [15:0] ctrl,
                                                  input logic a,
                                                  input logic b,
                                                  input logic fa,
                                                  input logic fb);
    logic [15:0] w;
    w = ctrl;
    w[jsm_pkg::F_A_ST] = a;
    w[jsm_pkg::F_B_ST] = b;
    w[jsm_pkg::F_A_FLAG] = fa;
    w[jsm_pkg::F_B_FLAG] = fb;
    return w;
  endfunction : jsm_ctrl_word_f

  // next-state logic
  always_comb begin
    logic a;
    logic b;
    logic chg_a;
    logic chg_b;
    logic mix_on;
    logic [15:0] rd_word;
    logic wr_ctrl;
    wr_ctrl = 1'b0;
    a = 1'b0;
    b = 1'b0;
    chg_a = 1'b0;
    chg_b = 1'b0;
    mix_on = 1'b0;
    rd_word = 16'h0000;
    st_nxt = st_r;
    // two-stage synchronisers, detect 1 = plug in
    st_nxt.sync_a = {st_r.sync_a[0], i_plug_detect_a};
    st_nxt.sync_b = {st_r.sync_b[0], i_plug_detect_b};
    a = st_r.sync_a[1]; // RULE8
    b = st_r.sync_b[1]; // RULE8
    st_nxt.det_a_q = a;
    st_nxt.det_b_q = b;
    chg_a = jsm_change_f(a, st_r.det_a_q);
    chg_b = jsm_change_f(b, st_r.det_b_q);
    // register writes
    wr_ctrl = i_wr && jsm_hit_f(i_addr, jsm_pkg::ADDR_JACK_SENSE);
    if (wr_ctrl) begin
      st_nxt.ctrl = i_wdata & jsm_pkg::WR_MASK;
    end
    if (i_wr && jsm_hit_f(i_addr, jsm_pkg::ADDR_MIXDOWN_SEL)) begin
      st_nxt.mix_sel = i_wdata[1:0];
    end
    // state change sets flag; set wins over clear
    st_nxt.flag_a = jsm_flag_f(st_r.flag_a, chg_a,
                               wr_ctrl && !i_wdata[jsm_pkg::F_A_FLAG]);
    st_nxt.flag_b = jsm_flag_f(st_r.flag_b, chg_b,
                               wr_ctrl && !i_wdata[jsm_pkg::F_B_FLAG]);
    // irq only from detects in interrupt mode
    st_nxt.irq = jsm_irq_f(st_r.flag_a, st_r.ctrl[jsm_pkg::F_A_MODE]) ||
                 jsm_irq_f(st_r.flag_b,
                           st_r.ctrl[jsm_pkg::F_B_MODE]); // RULE14
    // read data, one cycle after strobe
    rd_word = 16'h0000;
    if (jsm_hit_f(i_addr, jsm_pkg::ADDR_JACK_SENSE)) begin
      rd_word = jsm_ctrl_word_f(st_r.ctrl, a, b,
                                st_r.flag_a, st_r.flag_b);
    end else if (jsm_hit_f(i_addr, jsm_pkg::ADDR_MIXDOWN_SEL)) begin
      rd_word = {14'h0000, st_r.mix_sel};
    end
    st_nxt.rdata = i_rd ? rd_word : 16'h0000;
    // forced mute overrides volume, active leaves it alone
    st_nxt.mute = jsm_mute_f(st_r.ctrl[jsm_pkg::F_MUTE_HI:jsm_pkg::F_MUTE_LO],
                             a, b); // RULE6 RULE7
    // down-mix from software select or gated detects
    mix_on = jsm_gate_f(st_r.ctrl[jsm_pkg::F_A_MIX], a,
                        st_r.ctrl[jsm_pkg::F_B_MIX], b); // RULE9 RULE10
    st_nxt.mix_act = mix_on || st_r.mix_sel[1]; // RULE11
    st_nxt.mix_type = jsm_mix_type_f(st_r.mix_sel, mix_on); // RULE13
    // spread from software switch or gated jacks
    st_nxt.spread = jsm_spread_f(i_spread_sw,
                                 st_r.ctrl[jsm_pkg::F_SPREAD],
                                 a, b); // RULE12
    st_nxt.eqb = jsm_gate_f(st_r.ctrl[jsm_pkg::F_A_EQB], a,
                            st_r.ctrl[jsm_pkg::F_B_EQB], b); // RULE15
    // synchronous reset overrides everything above
    if (i_sys_rst) begin
      st_nxt = '0;
      st_nxt.ctrl = jsm_pkg::RESET_JACK_SENSE;
      st_nxt.mix_sel = jsm_pkg::RESET_MIXDOWN_SEL;
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    st_r <= st_nxt;
  end

  // outputs straight from state flops
  assign o_rdata = st_r.rdata;
  // forced mute per output
  assign o_mute_headphone = st_r.mute[4];
  assign o_mute_line = st_r.mute[3];
  assign o_mute_center_bass = st_r.mute[2];
  assign o_mute_rear = st_r.mute[1];
  assign o_mute_mono = st_r.mute[0];
  // down-mix and spread levels
  assign o_mixdown_active = st_r.mix_act;
  assign o_mixdown_type = st_r.mix_type;
  assign o_spread_active = st_r.spread;
  // equalizer bypass and interrupt
  assign o_eq_bypass = st_r.eqb;
  assign o_irq = st_r.irq;

endmodule : jsm_ctrl
`default_nettype wire

// ---- jsm_jack.sv ----
// partner model: jack switch with pull-down on its detect line
`timescale 1ns/1ps
`default_nettype none
module jsm_jack (
  input wire logic i_plugged,
  output logic o_detect
);
  // empty jack pulled down to 0, inserted plug reads 1
  assign o_detect = i_plugged;
endmodule : jsm_jack
`default_nettype wire

// ---- jsm_pkg.sv ----
// package: register map, field layout and codes for jack sense mute control
package jsm_pkg;
  // register indices on the plain port (byte address = index)
  localparam logic [7:0] ADDR_JACK_SENSE = 8'h72;
  localparam logic [7:0] ADDR_MIXDOWN_SEL = 8'h76;
  localparam logic [15:0] RESET_JACK_SENSE = 16'h0000;
  localparam logic [1:0] RESET_MIXDOWN_SEL = 2'h0;
  // field positions of jack_sense_control
  localparam int F_SPREAD = 15;
  localparam int F_B_MIX = 14;
  localparam int F_A_MIX = 13;
  localparam int F_MUTE_HI = 12;
  localparam int F_MUTE_LO = 10;
  localparam int F_B_EQB = 9;
  localparam int F_A_EQB = 8;
  localparam int F_B_MODE = 5;
  localparam int F_A_MODE = 4;
  localparam int F_B_ST = 3;
  localparam int F_A_ST = 2;
  localparam int F_B_FLAG = 1;
  localparam int F_A_FLAG = 0;
  // writable bits of jack_sense_control
  localparam logic [15:0] WR_MASK = 16'hff30;
  // mute selector codes
  localparam logic [2:0] MS_NONE = 3'h0;
  localparam logic [2:0] MS_LINE_B = 3'h1;
  localparam logic [2:0] MS_HP_B = 3'h2;
  localparam logic [2:0] MS_MIXED = 3'h4;
  localparam logic [2:0] MS_ALL_B = 3'h5;
  // mute vector bit order: hp, line, cb, rear, mono
  localparam logic [4:0] MV_NONE = 5'h00;
  localparam logic [4:0] MV_MONO = 5'h01;
  localparam logic [4:0] MV_LINE_CB_REAR = 5'h0e;
  localparam logic [4:0] MV_HP_CB_REAR = 5'h16;
  localparam logic [4:0] MV_HP_LINE_CB_REAR = 5'h1e;
  localparam logic [4:0] MV_ALL_BUT_HP = 5'h0f;
  // mixdown_select codes
  localparam logic [1:0] MX_CB = 2'h2;
  localparam logic [1:0] MX_CB_REAR = 2'h3;
  // mixdown type outputs
  localparam logic [1:0] MT_OFF = 2'h0;
  localparam logic [1:0] MT_CB = 2'h1;
  localparam logic [1:0] MT_CB_REAR = 2'h2;
endpackage : jsm_pkg

// ---- jsm_props.sv ----
// checker: port relations of the jack mute control
`timescale 1ns/1ps
`default_nettype none
module jsm_props (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_plug_detect_a,
  input wire logic i_plug_detect_b,
  input wire logic o_mute_headphone,
  input wire logic o_mute_line,
  input wire logic o_mute_center_bass,
  input wire logic o_mute_rear,
  input wire logic o_mute_mono,
  input wire logic o_mixdown_active,
  input wire logic [1:0] o_mixdown_type,
  input wire logic o_eq_bypass
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // mute vector only takes documented patterns
  AST_PATTERN: assert property ({o_mute_headphone, o_mute_line,
    o_mute_center_bass, o_mute_rear, o_mute_mono} inside
    {5'h00, 5'h01, 5'h0e, 5'h16, 5'h1e, 5'h0f}) else $error("bad mute");
  AST_HP_MONO: assert property (!(o_mute_headphone && o_mute_mono))
    else $error("hp and mono muted");
  AST_LINE_CB: assert property (o_mute_line |-> o_mute_center_bass)
    else $error("line without cb");
  AST_CB_REAR: assert property (o_mute_center_bass == o_mute_rear)
    else $error("cb and rear differ");
  // detect to output lag is three edges
  AST_HP_DET: assert property (o_mute_headphone |->
    !$past(i_plug_detect_b, 3)) else $error("hp mute with plug b");
  AST_MONO_DET: assert property (o_mute_mono |->
    $past(i_plug_detect_a, 3) || $past(i_plug_detect_b, 3))
    else $error("mono mute with empty jacks");
  AST_EQ_DET: assert property (o_eq_bypass |->
    $past(i_plug_detect_a, 3) || $past(i_plug_detect_b, 3))
    else $error("eq bypass with empty jacks");
  AST_MIX_TYPE: assert property (o_mixdown_active ==
    (o_mixdown_type != 2'h0)) else $error("mixdown type mismatch");
endmodule : jsm_props
bind jsm_ctrl jsm_props u_props (.*);
`default_nettype wire

// ---- tb.sv ----
// testbench: random jack states and register settings
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clk, i_sys_rst, i_wr, i_rd, i_spread_sw, pa, pb;
  logic i_plug_detect_a, i_plug_detect_b, o_mute_headphone, o_mute_line;
  logic o_mute_center_bass, o_mute_rear, o_mute_mono, o_mixdown_active;
  logic o_spread_active, o_eq_bypass, o_irq;
  logic [1:0] o_mixdown_type;
  logic [7:0] i_addr;
  logic [15:0] i_wdata, o_rdata, w, s;
  int miscompares, check_count, n;
  jsm_ctrl i_dut (.*);
  jsm_jack u_ja (.i_plugged(pa), .o_detect(i_plug_detect_a));
  jsm_jack u_jb (.i_plugged(pb), .o_detect(i_plug_detect_b));
  // clock and watchdog
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    end_sim;
  end
  // expected mute vector: hp, line, cb, rear, mono
  function logic [15:0] mv(input logic [2:0] c, input logic a, b);
    case (c)
      3'h1: mv = b ? 16'h01 : 16'h0e;
      3'h2: mv = b ? 16'h01 : 16'h16;
      3'h4: mv = b ? 16'h0f : (a ? 16'h01 : 16'h0e);
      3'h5: mv = b ? 16'h01 : 16'h1e;
      default: mv = 16'h00;
    endcase
  endfunction : mv
  task cmp(input string nm, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 cmp("rdata", e, o_rdata);
  endtask : rd
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    {i_sys_rst, i_wr, i_rd, i_spread_sw, pa, pb} = 6'h20;
    {i_addr, i_wdata, miscompares, check_count} = '0;
    n = $urandom(15);
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(8'h72, 16'h0000);
    wr(8'h10, 16'hffff);
    rd(8'h10, 16'h0000);
    for (n = 0; n < 48; n++) begin
      @(posedge i_clk);
      pa <= $urandom;
      pb <= $urandom;
      i_spread_sw <= $urandom;
      w = $urandom;
      w[1:0] = 2'h0;
      s = $urandom;
      repeat (4) @(posedge i_clk);
      wr(8'h72, w);
      wr(8'h76, s);
      repeat (4) @(posedge i_clk);
      #1 cmp("mute", mv(w[12:10], pa, pb), 16'({o_mute_headphone, o_mute_line,
        o_mute_center_bass, o_mute_rear, o_mute_mono}));
      cmp("mix", 16'(w[13] & pa | w[14] & pb | s[1]), 16'(o_mixdown_active));
      cmp("eqb", 16'(w[8] & pa | w[9] & pb), 16'(o_eq_bypass));
      cmp("mxt", 16'(s[1:0] == 2'h3 ? 2'h2 : s[1:0] == 2'h2 ? 2'h1 :
        (w[13] & pa | w[14] & pb) ? 2'h2 : 2'h0), 16'(o_mixdown_type));
      cmp("spr", 16'(i_spread_sw | w[15] & (pa | pb)), 16'(o_spread_active));
      cmp("irq", 16'h0, 16'(o_irq));
      rd(8'h72, w & 16'hff30 | 16'({pb, pa, 2'h0}));
      rd(8'h76, 16'(s[1:0]));
      @(posedge i_clk);
      pa <= ~pa;
      repeat (5) @(posedge i_clk);
      #1 cmp("irq", 16'(w[4]), 16'(o_irq));
    end
    end_sim;
  end
endmodule : tb
`default_nettype wire
